// >>> design/heater_jobs_defines.svh
// Job codes, entry lengths, code values and fixed values for the job handler
`ifndef HEATER_JOBS_DEFINES_SVH
`define HEATER_JOBS_DEFINES_SVH

// Job codes seen on the job port
`define JOB_CH_FAULT 8'h15
`define JOB_CH_ALARM 8'h16
`define JOB_DIAG_RUN 8'h17
`define JOB_CTL_OUT 8'h1E
`define JOB_ACT_VAL 8'h1F
`define JOB_TEMP 8'h20
`define JOB_RESET 8'h28

// Channel fault codes
`define FLT_OK 8'h00
`define FLT_TYPE1 8'h01
`define FLT_TYPE2 8'h02
`define FLT_TYPE2_EXT 8'h03
`define FLT_TYPE3 8'h04
`define FLT_TYPE4 8'h05
`define FLT_TYPE5 8'h06

// Channel alarm codes
`define ALM_OK 8'h00
`define ALM_SETPOINT_FIELD 8'h01
`define ALM_LINE_COMP 8'h02

// Entry lengths in bytes
`define LEN_ENTRY 3'h3
`define LEN_ACT 3'h6

// Largest controller output value
`define CTL_MAX 7'h64

// Marker values for measured quantities
`define VAL_INVALID 16'hFFFF
`define TEMP_RELAY 16'h0000

`endif

// >>> design/heater_jobs_pkg.sv
// Types shared by the job handler
package heater_jobs_pkg;

	// Job handler states, one-hot
	typedef enum logic [10:0] {
		ST_IDLE = 11'b000_0000_0001,
		ST_FLT = 11'b000_0000_0010,
		ST_ALM = 11'b000_0000_0100,
		ST_DIAG = 11'b000_0000_1000,
		ST_DWAIT = 11'b000_0001_0000,
		ST_CTL = 11'b000_0010_0000,
		ST_ACT = 11'b000_0100_0000,
		ST_TMP = 11'b000_1000_0000,
		ST_DONE = 11'b001_0000_0000,
		ST_RST = 11'b010_0000_0000,
		ST_RGO = 11'b100_0000_0000
	} job_state_e;

endpackage : heater_jobs_pkg

// >>> design/chan_buf.sv
// Per-channel code store with changed markers
`timescale 1ns/1ps
`include "heater_jobs_defines.svh"

module chan_buf #(
	parameter int N = 128,
	parameter int CW = 7
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic upd,
	input wire logic [CW-1:0] upd_idx,
	input wire logic [7:0] upd_code,
	input wire logic [CW-1:0] rd_idx,
	input wire logic clr,
	output logic [7:0] rd_code,
	output logic rd_chg
);
	// Stored codes, one per channel
	logic [7:0] code_r [N];
	// Changed markers
	logic [N-1:0] chg_r;
	logic [N-1:0] chg_nxt;
	// A new code that differs from the stored one
	wire set = upd && (upd_code != code_r[upd_idx]);

	assign rd_code = code_r[rd_idx];
	assign rd_chg = chg_r[rd_idx];

	// Marker update; a set in the clearing cycle wins
	always_comb
	begin
		chg_nxt = chg_r;
		if (clr)
			chg_nxt[rd_idx] = 1'b0; // [RULE20]
		if (set)
			chg_nxt[upd_idx] = 1'b1; // [RULE20]
	end

	// Storage; reading never touches the codes
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			chg_r <= '0;
			for (int i = 0; i < N; i++)
				code_r[i] <= 8'h00;
		end
		else
		begin
			chg_r <= chg_nxt;
			if (upd)
				code_r[upd_idx] <= upd_code; // [RULE1] [RULE4]
		end
	end

endmodule : chan_buf

// >>> design/entry_tx.sv
// Byte serialiser for one response entry of up to six bytes
`timescale 1ns/1ps

module entry_tx #(
	parameter int NB = 6
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [2:0] len,
	input wire logic [8*NB-1:0] word,
	input wire logic flush,
	input wire logic ready,
	output logic valid,
	output logic [7:0] data,
	output logic idle
);
	// Entry bytes, first byte at the top
	logic [8*NB-1:0] buf_r;
	// Bytes still to send
	logic [2:0] cnt_r;
	logic valid_r;

	assign valid = valid_r;
	assign data = buf_r[8*NB-1 -: 8];
	assign idle = (cnt_r == 3'h0);

	// Load when empty, shift on each accepted byte, flush drops all
	always_ff @(posedge core_clk)
	begin
		if (!rstn || flush)
		begin
			buf_r <= '0;
			cnt_r <= 3'h0;
			valid_r <= 1'b0;
		end
		else if (load && idle)
		begin
			buf_r <= word;
			cnt_r <= len;
			valid_r <= (len != 3'h0);
		end
		else if (valid_r && ready)
		begin
			buf_r <= buf_r << 8;
			cnt_r <= cnt_r - 3'h1;
			valid_r <= (cnt_r != 3'h1);
		end
	end

endmodule : entry_tx

// >>> design/heater_jobs.sv
// Acyclic job handler: readout jobs, one-off diagnostic cycle and reset
// Function
// RULE1 - Fault job reads buffer, never clears it
// RULE2 - Only changed entries; empty reply means nothing
// RULE3 - Entry: channel number, then fault code
// RULE4 - Alarm job: changed entries, buffer kept
// RULE5 - Entry: channel number, then alarm code
// RULE6 - Diag job runs one cycle, always accepted; code takes it only when idle
// RULE7 - Diag results sent at once, bypass buffer
// RULE8 - Diag covers every channel of detected modules
// RULE9 - Output readout for all detected channels, 0..100
// RULE10 - Output value is the combined corrected value
// RULE11 - Output entry: channel, flag bit7, value bits6-0
// RULE12 - Actual values: channel, current, power
// RULE13 - Measured values valid only when conditions met
// RULE14 - Temperature per module; relay 0, invalid FFFF
// RULE15 - Over upper threshold marks temperature invalid
// RULE16 - Reset job acknowledged, then restart
// RULE17 - Reset job has no data, accepted always
// RULE18 - Master reinitialises after reset
// RULE19 - Master reads faults/alarms when flagged
// RULE20 - Changed markers cleared once reported
`timescale 1ns/1ps
`include "heater_jobs_defines.svh"

module heater_jobs
	import heater_jobs_pkg::*;
#(
	parameter int NMOD = 16,
	parameter int CPM_LOG = 3
) (
	input wire logic core_clk,
	input wire logic rstn,
	// Job request
	input wire logic job_valid,
	input wire logic [7:0] job_code,
	input wire logic [15:0] job_chan,
	output logic job_busy,
	// Response byte stream
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	input wire logic rsp_ready,
	output logic rsp_done,
	// Fault and alarm updates from channel monitoring
	input wire logic flt_upd,
	input wire logic [15:0] flt_chan,
	input wire logic [7:0] flt_code,
	input wire logic alm_upd,
	input wire logic [15:0] alm_chan,
	input wire logic [7:0] alm_code,
	// Modules found at start-up
	input wire logic [NMOD-1:0] mod_present,
	input wire logic [NMOD-1:0] mod_relay,
	input wire logic [NMOD-1:0] mod_overtemp,
	// Index of channel or module whose data is shown below
	output logic [$clog2(NMOD)+CPM_LOG-1:0] scan_idx,
	input wire logic [15:0] mod_temp,
	input wire logic [6:0] ctl_value,
	input wire logic ctl_flag,
	input wire logic [15:0] meas_current,
	input wire logic [15:0] meas_power,
	input wire logic init_done,
	input wire logic mode_active,
	input wire logic ext_cur_diag,
	// One-off diagnostic cycle
	output logic diag_run,
	output logic diag_req,
	input wire logic diag_ack,
	input wire logic [7:0] diag_code,
	// Software restart request
	output logic sw_reset
);
	localparam int MW = $clog2(NMOD);
	localparam int CW = MW + CPM_LOG;
	localparam int NCH = NMOD << CPM_LOG;

	// Handler state and scan index
	job_state_e state_r;
	job_state_e state_nxt;
	logic [CW-1:0] idx_r;
	logic [CW-1:0] idx_nxt;
	// Output flops
	logic busy_r;
	logic done_r;
	logic reset_r;
	logic diag_run_r;
	logic diag_req_r;
	// Per-cycle controls
	logic done_nxt;
	logic reset_nxt;
	logic diag_req_nxt;
	logic tx_load;
	logic [2:0] tx_len;
	logic [47:0] tx_word;
	logic flt_clr;
	logic alm_clr;
	// Buffer reads
	logic [7:0] flt_rd;
	logic flt_chg;
	logic [7:0] alm_rd;
	logic alm_chg;
	logic tx_idle;

	// Decoding
	wire reset_job = job_valid && (job_code == `JOB_RESET);
	wire [15:0] chan_num = {{(16-CW){1'b0}}, idx_r} + 16'h0001;
	wire [15:0] job_chan_m1 = job_chan - 16'h0001;
	wire [CW-1:0] job_idx = job_chan_m1[CW-1:0];
	wire [MW-1:0] mod_idx = idx_r[CW-1:CPM_LOG];
	wire [MW-1:0] tmp_idx = idx_r[MW-1:0];
	wire chan_present = mod_present[mod_idx];
	wire last_ch = (idx_r == CW'(NCH - 1));
	wire last_mod = (tmp_idx == MW'(NMOD - 1));
	wire [7:0] mod_num = {{(8-MW){1'b0}}, tmp_idx} + 8'h01;
	// Saturate the combined output value to its top
	wire [6:0] ctl_sat = (ctl_value > `CTL_MAX) ? `CTL_MAX : ctl_value; // [RULE9] [RULE10]
	// Measured values hold only when every condition is met
	wire meas_ok = init_done && mode_active && ext_cur_diag; // [RULE13]
	wire [15:0] cur_val = meas_ok ? meas_current : `VAL_INVALID; // [RULE13]
	wire [15:0] pow_val = meas_ok ? meas_power : `VAL_INVALID; // [RULE13]
	// Relay slots read zero, over-threshold reads invalid
	wire [15:0] temp_val = mod_relay[tmp_idx] ? `TEMP_RELAY :
		(mod_overtemp[tmp_idx] ? `VAL_INVALID : mod_temp); // [RULE14] [RULE15]

	assign job_busy = busy_r;
	assign rsp_done = done_r;
	assign sw_reset = reset_r;
	assign diag_run = diag_run_r;
	assign diag_req = diag_req_r;
	assign scan_idx = idx_r;

	// Channel fault buffer
	chan_buf #(
		.N(NCH),
		.CW(CW)
	) u_flt_buf (
		.core_clk(core_clk),
		.rstn(rstn),
		.upd(flt_upd),
		.upd_idx(flt_chan[CW-1:0]),
		.upd_code(flt_code),
		.rd_idx(idx_r),
		.clr(flt_clr),
		.rd_code(flt_rd),
		.rd_chg(flt_chg)
	);

	// Channel alarm buffer, kept apart from faults
	chan_buf #(
		.N(NCH),
		.CW(CW)
	) u_alm_buf (
		.core_clk(core_clk),
		.rstn(rstn),
		.upd(alm_upd),
		.upd_idx(alm_chan[CW-1:0]),
		.upd_code(alm_code),
		.rd_idx(idx_r),
		.clr(alm_clr),
		.rd_code(alm_rd),
		.rd_chg(alm_chg)
	);

	// Response serialiser; a reset job drops any pending bytes
	entry_tx #(
		.NB(6)
	) u_tx (
		.core_clk(core_clk),
		.rstn(rstn),
		.load(tx_load),
		.len(tx_len),
		.word(tx_word),
		.flush(reset_job),
		.ready(rsp_ready),
		.valid(rsp_valid),
		.data(rsp_data),
		.idle(tx_idle)
	);

	// Next state, scan stepping and entry formation
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		tx_load = 1'b0;
		tx_len = `LEN_ENTRY;
		tx_word = 48'h0000_0000_0000;
		flt_clr = 1'b0;
		alm_clr = 1'b0;
		diag_req_nxt = 1'b0;
		done_nxt = 1'b0;
		reset_nxt = 1'b0;
		unique case (state_r)
			ST_IDLE:
			begin
				// Start a job; scans begin at the first index
				if (job_valid)
				begin
					idx_nxt = '0;
					if (job_code == `JOB_CH_FAULT)
						state_nxt = ST_FLT;
					else if (job_code == `JOB_CH_ALARM)
						state_nxt = ST_ALM;
					else if (job_code == `JOB_DIAG_RUN)
						state_nxt = ST_DIAG; // [RULE6]
					else if (job_code == `JOB_CTL_OUT)
						state_nxt = ST_CTL;
					else if (job_code == `JOB_ACT_VAL)
					begin
						idx_nxt = job_idx;
						state_nxt = ST_ACT;
					end
					else if (job_code == `JOB_TEMP)
						state_nxt = ST_TMP;
					else if (reset_job)
						state_nxt = ST_RST; // [RULE17]
					else
						state_nxt = ST_DONE;
				end
			end
			ST_FLT:
			begin
				// Send changed fault entries only, clearing their markers
				if (!flt_chg || tx_idle)
				begin
					tx_load = flt_chg; // [RULE2]
					tx_word = {chan_num, flt_rd, 24'h00_0000}; // [RULE3] [RULE1]
					flt_clr = flt_chg; // [RULE20]
					if (last_ch)
						state_nxt = ST_DONE;
					else
						idx_nxt = idx_r + 1'b1;
				end
			end
			ST_ALM:
			begin
				// Send changed alarm entries only, clearing their markers
				if (!alm_chg || tx_idle)
				begin
					tx_load = alm_chg; // [RULE4]
					tx_word = {chan_num, alm_rd, 24'h00_0000}; // [RULE5]
					alm_clr = alm_chg; // [RULE20]
					if (last_ch)
						state_nxt = ST_DONE;
					else
						idx_nxt = idx_r + 1'b1;
				end
			end
			ST_DIAG:
			begin
				// Test every channel of a detected module, loaded or not
				if (!chan_present)
				begin
					if (last_ch)
						state_nxt = ST_DONE;
					else
						idx_nxt = idx_r + 1'b1;
				end
				else if (tx_idle)
				begin
					diag_req_nxt = 1'b1; // [RULE8]
					state_nxt = ST_DWAIT;
				end
			end
			ST_DWAIT:
			begin
				// Result goes straight out, never into the fault buffer
				if (diag_ack)
				begin
					tx_load = 1'b1; // [RULE7]
					tx_word = {chan_num, diag_code, 24'h00_0000}; // [RULE7]
					if (last_ch)
						state_nxt = ST_DONE;
					else
					begin
						idx_nxt = idx_r + 1'b1;
						state_nxt = ST_DIAG;
					end
				end
			end
			ST_CTL:
			begin
				// One output entry per detected channel
				if (!chan_present || tx_idle)
				begin
					tx_load = chan_present; // [RULE9]
					tx_word = {chan_num, ctl_flag, ctl_sat, 24'h00_0000}; // [RULE11]
					if (last_ch)
						state_nxt = ST_DONE;
					else
						idx_nxt = idx_r + 1'b1;
				end
			end
			ST_ACT:
			begin
				// Addressed channel: number, current, power
				if (tx_idle)
				begin
					tx_load = 1'b1;
					tx_len = `LEN_ACT;
					tx_word = {chan_num, cur_val, pow_val}; // [RULE12]
					state_nxt = ST_DONE;
				end
			end
			ST_TMP:
			begin
				// One temperature entry per detected module
				if (!mod_present[tmp_idx] || tx_idle)
				begin
					tx_load = mod_present[tmp_idx]; // [RULE14]
					tx_word = {mod_num, temp_val, 24'h00_0000}; // [RULE14]
					if (last_mod)
						state_nxt = ST_DONE;
					else
						idx_nxt = idx_r + 1'b1;
				end
			end
			ST_DONE:
			begin
				// Close the reply once the last byte has gone
				if (tx_idle)
				begin
					done_nxt = 1'b1; // [RULE2]
					state_nxt = ST_IDLE;
				end
			end
			ST_RST:
			begin
				// Acknowledge the reset job first
				if (tx_idle)
				begin
					done_nxt = 1'b1; // [RULE16]
					state_nxt = ST_RGO;
				end
			end
			ST_RGO:
			begin
				// Restart only after the acknowledgement
				reset_nxt = 1'b1; // [RULE16]
				state_nxt = ST_IDLE;
			end
		endcase
		// A reset job aborts any job in progress
		if (reset_job && (state_r != ST_IDLE))
		begin
			state_nxt = ST_RST; // [RULE17]
			tx_load = 1'b0;
			diag_req_nxt = 1'b0;
		end
	end

	// State and index
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_r <= ST_IDLE;
			idx_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
		end
	end

	// Registered outputs
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			reset_r <= 1'b0;
			diag_run_r <= 1'b0;
			diag_req_r <= 1'b0;
		end
		else
		begin
			busy_r <= (state_nxt != ST_IDLE);
			done_r <= done_nxt;
			reset_r <= reset_nxt;
			diag_run_r <= (state_nxt == ST_DIAG) || (state_nxt == ST_DWAIT); // [RULE6]
			diag_req_r <= diag_req_nxt;
		end
	end

endmodule : heater_jobs

// >>> sim/heater_jobs_asserts.sv
// Port checker for the job handler
`timescale 1ns/1ps
`include "heater_jobs_defines.svh"

module heater_jobs_asserts (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic job_valid,
	input wire logic [7:0] job_code,
	input wire logic job_busy,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_ready,
	input wire logic rsp_done,
	input wire logic diag_run,
	input wire logic diag_req,
	input wire logic sw_reset
);
	// One clock domain, reset disables all checks
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	// Restart comes only after the acknowledge
	chk_ack_first: assert property (sw_reset |-> $past(rsp_done))
		else $error("restart without acknowledge");
	// A stalled byte stays put unless a reset job flushes it
	chk_byte_hold: assert property (
		rsp_valid && !rsp_ready && !(job_valid && job_code == `JOB_RESET)
		|=> rsp_valid && $stable(rsp_data))
		else $error("reply byte dropped or changed");
	// A job is taken when idle, a reset job always
	chk_job_taken: assert property (
		job_valid && (!job_busy || job_code == `JOB_RESET) |=> job_busy)
		else $error("job not taken");
	// A reset job ends in a restart
	chk_reset_runs: assert property (
		job_valid && job_code == `JOB_RESET |-> ##[2:16] sw_reset)
		else $error("reset job without restart");
	// Tests are asked only inside the diagnostic cycle
	chk_req_in_diag: assert property (diag_req |-> diag_run)
		else $error("test request outside cycle");
	// The diagnostic cycle belongs to a running job
	chk_diag_busy: assert property (diag_run |-> job_busy)
		else $error("diagnostic cycle while idle");
	// No reply bytes while idle
	chk_quiet_idle: assert property (!job_busy |-> !rsp_valid)
		else $error("reply byte while idle");
	// Every job ends with the end marker or a restart
	chk_end_marked: assert property ($fell(job_busy) |-> rsp_done || sw_reset)
		else $error("job ended without end marker");
endmodule : heater_jobs_asserts

bind heater_jobs heater_jobs_asserts u_chk (
	.core_clk(core_clk),
	.rstn(rstn),
	.job_valid(job_valid),
	.job_code(job_code),
	.job_busy(job_busy),
	.rsp_valid(rsp_valid),
	.rsp_data(rsp_data),
	.rsp_ready(rsp_ready),
	.rsp_done(rsp_done),
	.diag_run(diag_run),
	.diag_req(diag_req),
	.sw_reset(sw_reset)
);

// >>> sim/master_model.sv
// Fieldbus master model: takes reply bytes, may stall
`timescale 1ns/1ps

module master_model (
	input wire logic core_clk,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic slow,
	output logic rsp_ready
);
	logic [7:0] got[$]; // Bytes taken from the reply
	logic [1:0] ph_r = 2'h0; // Stall phase

	// Ready each cycle, or one cycle in four when slow
	assign rsp_ready = !slow || (ph_r == 2'h3);

	// Take a byte on handshake
	always @(posedge core_clk)
	begin
		ph_r <= ph_r + 2'h1;
		if (rsp_valid && rsp_ready)
			got.push_back(rsp_data);
	end
endmodule : master_model

// >>> sim/testbench.sv
// Self-checking bench for the job handler
`timescale 1ns/1ps
`include "heater_jobs_defines.svh"

module testbench;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic job_valid = 1'b0;
	logic [7:0] job_code = 8'h00;
	logic [15:0] job_chan = 16'h0000;
	logic flt_upd = 1'b0;
	logic alm_upd = 1'b0;
	logic [15:0] u_chan = 16'h0000; // Channel for either update port
	logic [7:0] u_code = 8'h00; // Code for either update port
	logic [15:0] mod_present = 16'hFFFF;
	logic [15:0] mod_relay = 16'h0000;
	logic [15:0] mod_overtemp = 16'h0000;
	logic [15:0] mod_temp = 16'h1234;
	logic [6:0] ctl_value = 7'h00;
	logic ctl_flag = 1'b0;
	logic [15:0] meas_current = 16'h0102;
	logic [15:0] meas_power = 16'h0304;
	logic init_done = 1'b1;
	logic mode_active = 1'b1;
	logic ext_cur_diag = 1'b1;
	logic diag_ack = 1'b0;
	logic [7:0] diag_code = 8'h00;
	logic mm_slow = 1'b0; // Master stalls
	logic job_busy, rsp_valid, rsp_ready, rsp_done, diag_run, diag_req, sw_reset;
	logic [7:0] rsp_data;
	logic [6:0] scan_idx;
	logic [7:0] q[$]; // Expected reply
	int err_total = 0;
	int n_checks = 0;

	// Clock, 25 ns period
	always #12.5 core_clk = ~core_clk;

	// Channel tester: answers each request a cycle later
	always @(posedge core_clk)
	begin
		diag_ack <= diag_req;
		diag_code <= {5'h00, 3'(scan_idx % 7)};
	end

	master_model mm (.core_clk(core_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.slow(mm_slow), .rsp_ready(rsp_ready));

	heater_jobs uut (.core_clk(core_clk), .rstn(rstn), .job_valid(job_valid),
		.job_code(job_code), .job_chan(job_chan), .job_busy(job_busy),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
		.rsp_done(rsp_done), .flt_upd(flt_upd), .flt_chan(u_chan), .flt_code(u_code),
		.alm_upd(alm_upd), .alm_chan(u_chan), .alm_code(u_code),
		.mod_present(mod_present), .mod_relay(mod_relay), .mod_overtemp(mod_overtemp),
		.scan_idx(scan_idx), .mod_temp(mod_temp), .ctl_value(ctl_value),
		.ctl_flag(ctl_flag), .meas_current(meas_current), .meas_power(meas_power),
		.init_done(init_done), .mode_active(mode_active), .ext_cur_diag(ext_cur_diag),
		.diag_run(diag_run), .diag_req(diag_req), .diag_ack(diag_ack),
		.diag_code(diag_code), .sw_reset(sw_reset));

	// Compare one value
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	end
	endtask : check

	// Issue a job, wait for its end, compare reply with q
	task automatic job(input logic [7:0] code);
		int n;
	begin
		mm.got.delete();
		job_valid <= 1'b1;
		job_code <= code;
		@(posedge core_clk);
		job_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		while (rsp_done !== 1'b1 && n < 4000);
		check("reply end", 16'h0001, {15'h0000, rsp_done});
		check("reply length", 16'(q.size()), 16'(mm.got.size()));
		if (q.size() == mm.got.size())
			foreach (q[i])
				check("reply byte", {8'h00, q[i]}, {8'h00, mm.got[i]});
		q.delete();
		@(posedge core_clk);
	end
	endtask : job

	// Pulse one fault or alarm update
	task automatic upd(input logic alm, input logic [15:0] ch, input logic [7:0] code);
	begin
		flt_upd <= !alm;
		alm_upd <= alm;
		u_chan <= ch;
		u_code <= code;
		@(posedge core_clk);
		flt_upd <= 1'b0;
		alm_upd <= 1'b0;
		@(posedge core_clk);
	end
	endtask : upd

	// Fault buffer: changes only, kept after reading
	task automatic t_fault;
	begin
		job(`JOB_CH_FAULT);
		job(8'h01);
		upd(1'b0, 16'h0005, `FLT_TYPE2_EXT);
		upd(1'b0, 16'h0009, `FLT_TYPE5);
		q = {8'h00, 8'h06, `FLT_TYPE2_EXT, 8'h00, 8'h0A, `FLT_TYPE5};
		job(`JOB_CH_FAULT);
		upd(1'b0, 16'h0009, `FLT_TYPE5);
		job(`JOB_CH_FAULT);
		upd(1'b0, 16'h0005, `FLT_OK);
		q = {8'h00, 8'h06, `FLT_OK};
		job(`JOB_CH_FAULT);
		$display("fault test ended");
	end
	endtask : t_fault

	// Alarm buffer, last channel included
	task automatic t_alarm;
	begin
		upd(1'b1, 16'h007F, `ALM_LINE_COMP);
		upd(1'b1, 16'h0002, `ALM_SETPOINT_FIELD);
		q = {8'h00, 8'h03, `ALM_SETPOINT_FIELD, 8'h00, 8'h80, `ALM_LINE_COMP};
		job(`JOB_CH_ALARM);
		job(`JOB_CH_ALARM);
		$display("alarm test ended");
	end
	endtask : t_alarm

	// Diagnostic cycle on one module with a stalling master
	task automatic t_diag;
	begin
		mod_present <= 16'h0001;
		mm_slow <= 1'b1;
		for (int i = 0; i < 8; i++)
			q = {q, 8'h00, 8'(i + 1), 8'(i % 7)};
		job(`JOB_DIAG_RUN);
		mm_slow <= 1'b0;
		job(`JOB_CH_FAULT);
		$display("diagnostic test ended");
	end
	endtask : t_diag

	// Output readout saturates and keeps the flag
	task automatic t_ctl;
	begin
		ctl_value <= 7'h7F;
		ctl_flag <= 1'b1;
		for (int i = 0; i < 8; i++)
			q = {q, 8'h00, 8'(i + 1), 8'hE4};
		job(`JOB_CTL_OUT);
		$display("output test ended");
	end
	endtask : t_ctl

	// Temperatures: normal, relay slot, over threshold
	task automatic t_temp;
	begin
		mod_present <= 16'h0007;
		mod_relay <= 16'h0002;
		mod_overtemp <= 16'h0004;
		q = {8'h01, 8'h12, 8'h34, 8'h02, 8'h00, 8'h00, 8'h03, 8'hFF, 8'hFF};
		job(`JOB_TEMP);
		$display("temperature test ended");
	end
	endtask : t_temp

	// Measured values, valid then invalid
	task automatic t_act;
	begin
		job_chan <= 16'h0003;
		q = {8'h00, 8'h03, 8'h01, 8'h02, 8'h03, 8'h04};
		job(`JOB_ACT_VAL);
		ext_cur_diag <= 1'b0;
		q = {8'h00, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		job(`JOB_ACT_VAL);
		$display("measured value test ended");
	end
	endtask : t_act

	// Reset job while busy: acknowledge, then restart
	task automatic t_reset;
		int n;
	begin
		job_valid <= 1'b1;
		job_code <= `JOB_CH_FAULT;
		@(posedge core_clk);
		job_code <= `JOB_RESET;
		@(posedge core_clk);
		job_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		while (rsp_done !== 1'b1 && n < 20);
		check("reset ack", 16'h0001, {15'h0000, rsp_done});
		check("early restart", 16'h0000, {15'h0000, sw_reset});
		@(posedge core_clk);
		#1;
		check("restart", 16'h0001, {15'h0000, sw_reset});
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		$display("reset test ended");
	end
	endtask : t_reset

	// Print counts and verdict, then stop
	task automatic end_of_test;
	begin
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask : end_of_test

	// Main sequence
	initial
	begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_fault();
		t_alarm();
		t_diag();
		t_ctl();
		t_temp();
		t_act();
		t_reset();
		end_of_test();
	end

	// Watchdog, several times the expected run
	initial
	begin
		#500000;
		err_total++;
		end_of_test();
	end
endmodule : testbench
